// >>> shared/rxpq_defines.vh
// register offsets, field positions, reset values and timing counts for the pass qualifier
`ifndef RXPQ_DEFINES_VH
`define RXPQ_DEFINES_VH
`define RXPQ_ADDR_PORT_SEL 8'h4c
`define RXPQ_ADDR_PASS_CTL 8'h7d
`define RXPQ_ADDR_RISE_MASK 8'h7e
`define RXPQ_ADDR_FALL_MASK 8'h7f
`define RXPQ_ADDR_RSVD_RW_LO 8'ha0
`define RXPQ_ADDR_RSVD_RW_HI 8'ha4
`define RXPQ_ADDR_REFCLK 8'ha5
`define RXPQ_ADDR_RSVD_RO_LO 8'ha7
`define RXPQ_ADDR_RSVD_RO_HI 8'haf
`define RXPQ_BIT_DISCARD 7
`define RXPQ_BIT_HEIGHT 5
`define RXPQ_BIT_WIDTH 4
`define RXPQ_BIT_PARITY 3
`define RXPQ_BIT_WDOG_OFF 2
`define RXPQ_THR_HI 1
`define RXPQ_THR_LO 0
`define RXPQ_RST_BYTE 8'h00
`define RXPQ_WDOG_FRAMES 2
`define RXPQ_GATE_US 1
`define RXPQ_CLK_MHZ 100
`define RXPQ_GATE_CYCLES (`RXPQ_GATE_US * `RXPQ_CLK_MHZ)
`endif

// >>> rtl/rxpq_pass_qualifier.v
// per-port video pass qualification, sensor edge latching and refclk measurement
`include "rxpq_defines.vh"
// Operation
// RULE1 - discard enable set: drop packets while pass is false; else forward all
// RULE2 - line-count check: frame height change drops pass until threshold met again
// RULE3 - line-size check: line width change drops pass until threshold met again
// RULE4 - parity policy 0 drops pass per error; 1 holds it until threshold
// RULE5 - software should set threshold 2 or more with sticky parity policy
// RULE6 - watchdog on: no frame end within two frame periods drops pass
// RULE7 - watchdog has no effect while threshold is zero
// RULE8 - nonzero threshold: pass only after that many valid frames
// RULE9 - zero threshold: pass as soon as receiver lock is seen
// RULE10 - masked rising sensor status edge latches rise status bit
// RULE11 - masked falling sensor status edge latches fall status bit
// RULE12 - read-only byte gives measured reference clock in whole MHz
// RULE13 - software reads frequency twice and accepts only matching values
// RULE14 - pass control and fall mask registers follow the port select
// RULE15 - bytes 0xa0 to 0xa4 are reserved read/write, reset zero
// RULE16 - bytes 0xa7 to 0xaf are reserved read-only zero
// RULE17 - edges found against previous-cycle value, one latch per event
module rxpq_pass_qualifier #(
    parameter NPORT = 2,
    parameter GATE_CYCLES = `RXPQ_GATE_CYCLES
) (
    input wire sys_clk,
    input wire rstn,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    output reg [7:0] reg_rdata,
    input wire [NPORT-1:0] rx_lock,
    input wire [NPORT-1:0] frame_start,
    input wire [NPORT-1:0] frame_end,
    input wire [NPORT-1:0] line_end,
    input wire [NPORT*16-1:0] line_words,
    input wire [NPORT-1:0] parity_err,
    input wire [NPORT-1:0] pkt_valid,
    output reg [NPORT-1:0] pkt_forward,
    output reg [NPORT-1:0] port_pass,
    input wire [NPORT*8-1:0] remote_sensor_status,
    output reg [NPORT*8-1:0] sensor_rise_latched,
    output reg [NPORT*8-1:0] sensor_fall_latched,
    input wire [NPORT-1:0] sensor_rise_clear,
    input wire [NPORT-1:0] sensor_fall_clear,
    input wire ref_clk_tick
);
    reg [7:0] port_select;
    reg [7:0] port_pass_control [0:NPORT-1];
    reg [7:0] sensor_rise_irq_mask [0:NPORT-1];
    reg [7:0] sensor_fall_irq_mask [0:NPORT-1];
    reg [7:0] reserved_block_a0 [0:4];
    reg [7:0] ref_clock_mhz;
    reg [7:0] ref_count;
    reg [15:0] gate_count;
    integer sel;
    integer k;
    integer j;
    // last count of the measurement gate, cut to the counter width on purpose
    localparam [15:0] GATE_LAST = GATE_CYCLES - 1;

    // port select picks the low bit(s) of 0x4c
    always @* begin
        sel = 0;
        for (k = 0; k < NPORT; k = k + 1) begin
            if (port_select[k])
                sel = k;
        end
    end

    // register writes; per-port registers reach the selected port
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            port_select <= 8'h01;
            for (j = 0; j < NPORT; j = j + 1) begin
                port_pass_control[j] <= `RXPQ_RST_BYTE;
                sensor_rise_irq_mask[j] <= `RXPQ_RST_BYTE;
                sensor_fall_irq_mask[j] <= `RXPQ_RST_BYTE;
            end
            for (j = 0; j < 5; j = j + 1)
                reserved_block_a0[j] <= `RXPQ_RST_BYTE; // [RULE15]
        end else if (reg_wr) begin
            case (reg_addr)
                `RXPQ_ADDR_PORT_SEL: port_select <= reg_wdata;
                `RXPQ_ADDR_PASS_CTL: port_pass_control[sel] <= reg_wdata; // [RULE14]
                `RXPQ_ADDR_RISE_MASK: sensor_rise_irq_mask[sel] <= reg_wdata;
                `RXPQ_ADDR_FALL_MASK: sensor_fall_irq_mask[sel] <= reg_wdata; // [RULE14]
                default: begin
                    if (reg_addr >= `RXPQ_ADDR_RSVD_RW_LO && reg_addr <= `RXPQ_ADDR_RSVD_RW_HI)
                        reserved_block_a0[reg_addr[2:0]] <= reg_wdata; // [RULE15]
                end
            endcase
        end
    end

    // registered read data; unmapped and 0xa7..0xaf read zero
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                `RXPQ_ADDR_PORT_SEL: reg_rdata <= port_select;
                `RXPQ_ADDR_PASS_CTL: reg_rdata <= port_pass_control[sel];
                `RXPQ_ADDR_RISE_MASK: reg_rdata <= sensor_rise_irq_mask[sel];
                `RXPQ_ADDR_FALL_MASK: reg_rdata <= sensor_fall_irq_mask[sel];
                `RXPQ_ADDR_REFCLK: reg_rdata <= ref_clock_mhz; // [RULE12]
                default: begin
                    if (reg_addr >= `RXPQ_ADDR_RSVD_RW_LO && reg_addr <= `RXPQ_ADDR_RSVD_RW_HI)
                        reg_rdata <= reserved_block_a0[reg_addr[2:0]];
                    else
                        reg_rdata <= 8'h00; // [RULE16]
                end
            endcase
        end
    end

    // refclk ticks counted over a 1 us gate give whole MHz; not tied to reads
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            gate_count <= 16'h0000;
            ref_count <= 8'h00;
            ref_clock_mhz <= 8'h00;
        end else if (gate_count == GATE_LAST) begin
            gate_count <= 16'h0000;
            ref_clock_mhz <= ref_count + {7'h00, ref_clk_tick}; // [RULE12]
            ref_count <= 8'h00;
        end else begin
            gate_count <= gate_count + 16'h0001;
            if (ref_clk_tick && ref_count != 8'hff)
                ref_count <= ref_count + 8'h01;
        end
    end

    genvar p;
    generate
        for (p = 0; p < NPORT; p = p + 1) begin : g_port
            reg [7:0] sts_prev;
            reg [15:0] lines_in_frame;
            reg [15:0] last_lines;
            reg [15:0] last_width;
            reg have_height;
            reg have_width;
            reg [1:0] good_frames;
            reg frame_bad;
            reg [31:0] period;
            reg [31:0] since_end;
            reg have_period;
            reg next_pass;
            reg [1:0] next_good_frames;
            reg next_frame_bad;
            wire [7:0] ctl = port_pass_control[p];
            wire [1:0] thr = ctl[`RXPQ_THR_HI:`RXPQ_THR_LO];
            wire discard_en = ctl[`RXPQ_BIT_DISCARD];
            wire frame_height_check = ctl[`RXPQ_BIT_HEIGHT];
            wire line_width_check = ctl[`RXPQ_BIT_WIDTH];
            wire parity_sticky = ctl[`RXPQ_BIT_PARITY];
            wire frame_end_watchdog_off = ctl[`RXPQ_BIT_WDOG_OFF];
            wire [7:0] sts = remote_sensor_status[p*8 +: 8];
            wire [7:0] rise_edges = sts & ~sts_prev;
            wire [7:0] fall_edges = ~sts & sts_prev;
            wire [15:0] width_now = line_words[p*16 +: 16];
            // one bit wider so a count of three cannot wrap to zero
            wire [2:0] frames_after = {1'b0, good_frames} + 3'b001;
            wire height_change = frame_height_check && frame_end[p] && have_height &&
                lines_in_frame != last_lines; // [RULE2]
            wire width_change = line_width_check && line_end[p] && have_width &&
                width_now != last_width; // [RULE3]
            // watchdog needs a measured period; zero threshold masks it
            wire wdog_trip = !frame_end_watchdog_off && thr != 2'b00 && have_period &&
                since_end >= `RXPQ_WDOG_FRAMES * period; // [RULE6] [RULE7]
            wire sticky_parity_hit = parity_err[p] && parity_sticky; // [RULE4]
            wire disqualify = height_change || width_change || wdog_trip || sticky_parity_hit;

            // previous-cycle copy; resets to the idle level so no false edge follows reset
            always @(posedge sys_clk or negedge rstn) begin
                if (!rstn) begin
                    sts_prev <= 8'h00;
                end else begin
                    sts_prev <= sts; // [RULE17]
                end
            end

            // a new edge wins over a clear in the same cycle
            always @(posedge sys_clk or negedge rstn) begin
                if (!rstn) begin
                    sensor_rise_latched[p*8 +: 8] <= 8'h00;
                end else begin
                    sensor_rise_latched[p*8 +: 8] <=
                        (sensor_rise_latched[p*8 +: 8] & ~{8{sensor_rise_clear[p]}}) |
                        (rise_edges & sensor_rise_irq_mask[p]); // [RULE10] [RULE17]
                end
            end

            always @(posedge sys_clk or negedge rstn) begin
                if (!rstn) begin
                    sensor_fall_latched[p*8 +: 8] <= 8'h00;
                end else begin
                    sensor_fall_latched[p*8 +: 8] <=
                        (sensor_fall_latched[p*8 +: 8] & ~{8{sensor_fall_clear[p]}}) |
                        (fall_edges & sensor_fall_irq_mask[p]); // [RULE11] [RULE17]
                end
            end

            // size of the last line; the first line after reset has nothing to compare
            always @(posedge sys_clk or negedge rstn) begin
                if (!rstn) begin
                    last_width <= 16'h0000;
                    have_width <= 1'b0;
                end else if (line_end[p]) begin
                    last_width <= width_now;
                    have_width <= 1'b1;
                end
            end

            // lines per frame, kept from the previous frame end
            always @(posedge sys_clk or negedge rstn) begin
                if (!rstn) begin
                    lines_in_frame <= 16'h0000;
                    last_lines <= 16'h0000;
                    have_height <= 1'b0;
                end else begin
                    if (frame_start[p]) begin
                        lines_in_frame <= 16'h0000;
                    end else if (line_end[p]) begin
                        lines_in_frame <= lines_in_frame + 16'h0001;
                    end
                    if (frame_end[p]) begin
                        last_lines <= lines_in_frame;
                        have_height <= 1'b1;
                    end
                end
            end

            // frame period end to end; saturates on a dead link instead of wrapping
            always @(posedge sys_clk or negedge rstn) begin
                if (!rstn) begin
                    period <= 32'h0;
                    since_end <= 32'h0;
                    have_period <= 1'b0;
                end else begin
                    if (frame_end[p]) begin
                        period <= since_end;
                        since_end <= 32'h0;
                    end else if (since_end != 32'hffffffff) begin
                        since_end <= since_end + 32'h1;
                    end
                    if (!rx_lock[p]) begin
                        have_period <= 1'b0;
                    end else if (frame_end[p]) begin
                        have_period <= 1'b1;
                    end
                end
            end

            // pass qualification
            always @* begin
                next_pass = port_pass[p];
                next_good_frames = good_frames;
                next_frame_bad = frame_bad;
                if (frame_start[p])
                    next_frame_bad = 1'b0;
                if (!rx_lock[p]) begin
                    next_pass = 1'b0;
                    next_good_frames = 2'b00;
                end else if (thr == 2'b00) begin
                    // zero threshold follows lock; only one-cycle drops apply
                    next_pass = !(parity_err[p] && !parity_sticky) && !height_change &&
                        !width_change; // [RULE9] [RULE7]
                    next_good_frames = 2'b00;
                end else if (disqualify) begin
                    // the frame in flight no longer counts toward the threshold
                    next_pass = 1'b0;
                    next_good_frames = 2'b00;
                    next_frame_bad = 1'b1;
                end else if (parity_err[p]) begin
                    next_pass = 1'b0; // [RULE4]
                end else if (frame_end[p]) begin
                    if (frame_bad) begin
                        next_frame_bad = 1'b0;
                    end else if (frames_after >= {1'b0, thr} || port_pass[p]) begin
                        next_pass = 1'b1; // [RULE8]
                        next_good_frames = thr;
                    end else begin
                        next_good_frames = frames_after[1:0]; // [RULE8]
                    end
                end else if (good_frames >= thr && !frame_bad) begin
                    next_pass = 1'b1; // [RULE4]
                end
            end

            always @(posedge sys_clk or negedge rstn) begin
                if (!rstn) begin
                    good_frames <= 2'b00;
                    frame_bad <= 1'b0;
                    port_pass[p] <= 1'b0;
                    pkt_forward[p] <= 1'b0;
                end else begin
                    good_frames <= next_good_frames;
                    frame_bad <= next_frame_bad;
                    port_pass[p] <= next_pass;
                    // gated by the pass level of the same cycle as the beat
                    pkt_forward[p] <= pkt_valid[p] && (!discard_en || port_pass[p]); // [RULE1]
                end
            end
        end
    endgenerate
endmodule // rxpq_pass_qualifier

// >>> dv/rxpq_pass_qualifier_monitor.sv
// port-level assertion checker for the pass qualifier
module rxpq_monitor #(
    parameter NPORT = 2
) (
    input wire sys_clk,
    input wire rstn,
    input wire reg_rd,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_rdata,
    input wire [NPORT-1:0] rx_lock,
    input wire [NPORT-1:0] pkt_valid,
    input wire [NPORT-1:0] pkt_forward,
    input wire [NPORT-1:0] port_pass,
    input wire [NPORT*8-1:0] remote_sensor_status,
    input wire [NPORT*8-1:0] sensor_rise_latched,
    input wire [NPORT*8-1:0] sensor_fall_latched,
    input wire [NPORT-1:0] sensor_rise_clear,
    input wire [NPORT-1:0] sensor_fall_clear
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    a_fwd_needs_beat: assert property (pkt_forward[0] |-> $past(pkt_valid[0]))
        else $error("forward without a packet beat");
    a_lock_loss_drop: assert property (!rx_lock[0] |=> !port_pass[0])
        else $error("pass held without lock");
    a_pass_after_lock: assert property ($rose(port_pass[0]) |-> $past(rx_lock[0]))
        else $error("pass rose without lock");
    a_rise_edge_cause: assert property ($rose(sensor_rise_latched[0]) |->
        $past(remote_sensor_status[0]) && !$past(remote_sensor_status[0], 2))
        else $error("rise latch without a rising edge");
    a_fall_edge_cause: assert property ($rose(sensor_fall_latched[1]) |->
        !$past(remote_sensor_status[1]) && $past(remote_sensor_status[1], 2))
        else $error("fall latch without a falling edge");
    a_rise_latch_held: assert property ($fell(sensor_rise_latched[0]) |-> $past(sensor_rise_clear[0]))
        else $error("rise latch lost without clear");
    a_fall_latch_held: assert property ($fell(sensor_fall_latched[1]) |-> $past(sensor_fall_clear[0]))
        else $error("fall latch lost without clear");
    a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data moved without a read");
    a_ro_rsvd_zero: assert property (reg_rd && reg_addr >= 8'ha7 && reg_addr <= 8'haf |=> reg_rdata == 8'h00)
        else $error("reserved read-only byte not zero");
endmodule // rxpq_monitor
bind rxpq_pass_qualifier rxpq_monitor #(.NPORT(NPORT)) u_rxpq_monitor (
    .sys_clk(sys_clk), .rstn(rstn), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_rdata(reg_rdata),
    .rx_lock(rx_lock), .pkt_valid(pkt_valid), .pkt_forward(pkt_forward), .port_pass(port_pass),
    .remote_sensor_status(remote_sensor_status), .sensor_rise_latched(sensor_rise_latched),
    .sensor_fall_latched(sensor_fall_latched), .sensor_rise_clear(sensor_rise_clear),
    .sensor_fall_clear(sensor_fall_clear));

// >>> dv/rxpq_ser_model.sv
// far-side serializer model: frames, line sizes, parity errors, sensor status
module rxpq_ser_model (
    input wire logic sys_clk,
    output logic fs,
    output logic fe,
    output logic le,
    output logic [15:0] lw,
    output logic pe,
    output logic [7:0] sts
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {fs, fe, le, pe, sts, lw} = 28'h000ffff;
    end
    task automatic set_sts(input logic [7:0] v);
        sts = v;
    endtask
    task automatic frame(input int lines, input logic [15:0] words, input bit perr);
        int i;
        @(negedge sys_clk) fs = 1'b1;
        @(negedge sys_clk) fs = 1'b0;
        for (i = 0; i < lines; i++) begin
            repeat (2) @(negedge sys_clk);
            {le, pe, lw} = {1'b1, perr && i == 0, words};
            @(negedge sys_clk) {le, pe, lw} = {2'b00, ~words}; // size not held past its pulse
        end
        @(negedge sys_clk) fe = 1'b1;
        @(negedge sys_clk) fe = 1'b0;
    endtask
endmodule // rxpq_ser_model

// >>> dv/rxpq_pass_qualifier_bench.sv
// self-checking bench for the pass qualifier
module rxpq_pass_qualifier_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk, rstn, reg_wr, reg_rd, tick, pv, rclr, fclr, fs, fe, le, pe;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, sts;
    logic [15:0] lw, rise, fall;
    logic [1:0] lock, fwd, pass;
    int n_mismatch, checks_done;
    rxpq_ser_model u_rxpq_ser_model (.sys_clk(sys_clk), .fs(fs), .fe(fe), .le(le), .lw(lw),
        .pe(pe), .sts(sts));
    // both ports see the same stream; only their locks and registers differ
    rxpq_pass_qualifier #(.NPORT(2), .GATE_CYCLES(10)) u_rxpq_pass_qualifier (
        .sys_clk(sys_clk), .rstn(rstn), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .rx_lock(lock), .frame_start({fs, fs}),
        .frame_end({fe, fe}), .line_end({le, le}), .line_words({lw, lw}),
        .parity_err({pe, pe}), .pkt_valid({pv, pv}), .pkt_forward(fwd), .port_pass(pass),
        .remote_sensor_status({sts, sts}), .sensor_rise_latched(rise),
        .sensor_fall_latched(fall), .sensor_rise_clear({rclr, rclr}),
        .sensor_fall_clear({fclr, fclr}), .ref_clk_tick(tick));
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    always @(negedge sys_clk) tick <= ~tick; // five ticks per ten-cycle gate
    task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk) {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
        @(negedge sys_clk) reg_wr = 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge sys_clk) {reg_rd, reg_addr} = {1'b1, a};
        @(negedge sys_clk) reg_rd = 1'b0;
        @(negedge sys_clk) chk("reg_rdata", {8'h00, exp}, {8'h00, reg_rdata});
    endtask
    task frame_pass(input int lines, input logic [15:0] words, input bit perr, input logic exp);
        u_rxpq_ser_model.frame(lines, words, perr);
        @(negedge sys_clk) chk("port_pass", {15'h0000, exp}, {15'h0000, pass[0]});
    endtask
    task t_regs;
        logic [7:0] a;
        for (a = 8'ha0; a <= 8'ha4; a++) begin
            rd(a, 8'h00);
            wr(a, 8'h5a);
            rd(a, 8'h5a);
            wr(a, 8'h00);
        end
        for (a = 8'ha7; a <= 8'haf; a++) begin
            wr(a, 8'hff);
            rd(a, 8'h00);
        end
        wr(8'h4c, 8'h02);
        wr(8'h7f, 8'h33);
        rd(8'h7e, 8'h00);
        wr(8'h4c, 8'h01);
        rd(8'h7f, 8'h00);
        wr(8'h4c, 8'h02);
        rd(8'h7f, 8'h33);
        wr(8'h7f, 8'h00);
        wr(8'h4c, 8'h01);
    endtask
    task t_pass;
        lock = 2'b11;
        repeat (2) @(negedge sys_clk);
        chk("port_pass", 16'h0003, {14'h0000, pass});
        lock = 2'b10;
        wr(8'h7d, 8'h06);
        lock = 2'b11;
        frame_pass(2, 16'h0028, 1'b0, 1'b0);
        frame_pass(2, 16'h0028, 1'b0, 1'b1);
        wr(8'h7d, 8'h0e);
        frame_pass(2, 16'h0028, 1'b1, 1'b0);
        frame_pass(2, 16'h0028, 1'b0, 1'b0);
        frame_pass(2, 16'h0028, 1'b0, 1'b1);
        wr(8'h7d, 8'ha6);
        frame_pass(3, 16'h0028, 1'b0, 1'b0);
        pv = 1'b1;
        @(negedge sys_clk) pv = 1'b0;
        chk("pkt_forward", 16'h0000, {15'h0000, fwd[0]});
        frame_pass(3, 16'h0028, 1'b0, 1'b0);
        frame_pass(3, 16'h0028, 1'b0, 1'b1);
        pv = 1'b1;
        @(negedge sys_clk) pv = 1'b0;
        chk("pkt_forward", 16'h0001, {15'h0000, fwd[0]});
        wr(8'h7d, 8'h16);
        frame_pass(3, 16'h0029, 1'b0, 1'b0);
        wr(8'h7d, 8'h02);
        frame_pass(3, 16'h0029, 1'b0, 1'b0);
        frame_pass(3, 16'h0029, 1'b0, 1'b1);
        repeat (40) @(negedge sys_clk);
        chk("port_pass", 16'h0000, {15'h0000, pass[0]});
        wr(8'h7d, 8'h00);
        repeat (40) @(negedge sys_clk);
        chk("port_pass", 16'h0001, {15'h0000, pass[0]});
    endtask
    task t_sensor;
        wr(8'h7e, 8'h01);
        wr(8'h7f, 8'h02);
        u_rxpq_ser_model.set_sts(8'h03);
        repeat (2) @(negedge sys_clk);
        chk("rise", 16'h0001, {8'h00, rise[7:0]});
        u_rxpq_ser_model.set_sts(8'h00);
        repeat (2) @(negedge sys_clk);
        chk("fall", 16'h0002, {8'h00, fall[7:0]});
        {rclr, fclr} = 2'b11;
        @(negedge sys_clk) {rclr, fclr} = 2'b00;
        @(negedge sys_clk) chk("cleared", 16'h0000, {rise[7:0], fall[7:0]});
        rd(8'ha5, 8'h05);
        rd(8'ha5, 8'h05);
    endtask
    task end_sim;
        $display("mismatches %0d checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        #400000;
        n_mismatch++;
        end_sim();
    end
    initial begin
        {rstn, reg_wr, reg_rd, tick, pv, rclr, fclr, lock, reg_addr, reg_wdata} = 25'h0000000;
        {n_mismatch, checks_done} = 64'h0;
        repeat (3) @(negedge sys_clk);
        rstn = 1'b1;
        t_regs();
        t_pass();
        t_sensor();
        end_sim();
    end
endmodule // rxpq_pass_qualifier_bench
